// ===== watchdog_regs.svh
// register map, field positions, reset values and timing counts of the watchdog
// assumes a 250 MHz aclk and a 32-bit AXI4-Lite register port
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

`define WDT_ADDR_W 8
`define WDT_FACTOR_ADDR 8'h00
`define WDT_UNIT_ADDR 8'h04
`define WDT_STATE_ADDR 8'h08
`define WDT_EVENT_ADDR 8'h0C
`define WDT_MASK_ADDR 8'h10

`define WDT_UNIT_SEC_BIT 0
`define WDT_UNIT_RESET 1'b1
`define WDT_STATE_RUN_BIT 0
`define WDT_STATE_UNIT_BIT 1
`define WDT_STATE_FIRE_BIT 2
`define WDT_EVT_EXPIRED_BIT 0
`define WDT_EVT_TRIGGER_BIT 1
`define WDT_EVT_DISABLE_BIT 2
`define WDT_EVT_W 3
`define WDT_EVENT_RESET 3'h0
`define WDT_MASK_RESET 3'h0
`define WDT_FACTOR_RESET 8'h00

`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`define WDT_CLK_PERIOD_NS 4
`define WDT_UNIT_TIME_NS 1000000000
`define WDT_SECOND_CYCLES (`WDT_UNIT_TIME_NS / `WDT_CLK_PERIOD_NS)
`define WDT_MINUTE_TICKS 60
`define WDT_RST_PULSE_NS 32
`define WDT_RST_PULSE_CYCLES ((`WDT_RST_PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)

`endif

// ===== watchdog_pkg.sv
// types shared by the watchdog modules
// assumes nothing of its surroundings
package watchdog_pkg;
    typedef enum logic [2:0] {
        WD_DISABLED = 3'b001,
        WD_COUNTING = 3'b010,
        WD_EXPIRED = 3'b100
    } wd_state_type;
endpackage

// ===== tick_if.sv
// carrier between the countdown logic and a tick divider
// assumes one clock domain
`timescale 1ns/100ps
interface tick_if;
    logic clear;
    logic advance;
    logic tick;
    modport source (input clear, input advance, output tick);
    modport sink (output clear, output advance, input tick);
endinterface

// ===== pulse_divider.sv
// divides advance pulses by LIMIT into a one-cycle tick
// assumes clear and advance come from the same clock domain
`timescale 1ns/100ps
module pulse_divider #(
    parameter int unsigned LIMIT = 60
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // tick carrier
    tick_if.source tk
);
    localparam int unsigned W = $clog2(LIMIT + 1);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    wire at_end = (cnt_reg == W'(LIMIT - 1));

    assign cnt_next = at_end ? '0 : cnt_reg + 1'b1;
    assign tk.tick = tk.advance && at_end && !tk.clear;

    // restart from zero so a trigger gives a whole unit
    always_ff @(posedge aclk) begin
        if (!aresetn || tk.clear) begin
            cnt_reg <= '0;
        end else if (tk.advance) begin
            cnt_reg <= cnt_next;
        end
    end

    property p_tick_spacing;
        @(posedge aclk) disable iff (!aresetn)
        tk.tick && (LIMIT > 1) |=> !tk.tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick repeated");
endmodule // pulse_divider

// ===== reset_pulse_gen.sv
// stretches a one-cycle fire request into a fixed-width reset pulse
// assumes fire is not raised again while the pulse is out
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module reset_pulse_gen #(
    parameter int unsigned CYCLES = `WDT_RST_PULSE_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request and pulse
    input wire logic fire,
    output logic active
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    logic [W-1:0] left_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_reg <= '0;
            active <= 1'b0;
        end else if (fire) begin
            left_reg <= W'(CYCLES - 1);
            active <= 1'b1;
        end else if (left_reg != '0) begin
            left_reg <= left_reg - 1'b1;
        end else begin
            active <= 1'b0;
        end
    end

    property p_pulse_width;
        @(posedge aclk) disable iff (!aresetn)
        $rose(active) |-> active [*8] ##1 !active;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("reset pulse width wrong");
endmodule // reset_pulse_gen

// ===== system_watchdog.sv
// programmable system watchdog behind an AXI4-Lite slave port
// assumes one 250 MHz clock, synchronous active-low reset, one master
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module system_watchdog #(
    parameter int unsigned SECOND_CYCLES = `WDT_SECOND_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [`WDT_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [`WDT_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // system side
    output logic system_reset,
    output logic activity_led,
    output logic irq
);
    // write channel capture
    logic aw_full_reg;
    logic w_full_reg;
    logic [`WDT_ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    assign awready = !aw_full_reg;
    assign wready = !w_full_reg;
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire do_write = aw_full_reg && w_full_reg && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            waddr_reg <= '0;
        end else if (aw_take) begin
            aw_full_reg <= 1'b1;
            waddr_reg <= awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (w_take) begin
            w_full_reg <= 1'b1;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    // write decode
    wire wsel_factor = (waddr_reg == `WDT_FACTOR_ADDR);
    wire wsel_unit = (waddr_reg == `WDT_UNIT_ADDR);
    wire wsel_state = (waddr_reg == `WDT_STATE_ADDR);
    wire wsel_event = (waddr_reg == `WDT_EVENT_ADDR);
    wire wsel_mask = (waddr_reg == `WDT_MASK_ADDR);
    wire wsel_ok = wsel_factor || wsel_unit || wsel_state || wsel_event || wsel_mask;
    wire lane0 = do_write && wstrb_reg[0];
    wire factor_write = lane0 && wsel_factor;
    wire [7:0] factor_in = wdata_reg[7:0];
    wire trigger_write = factor_write && (factor_in != 8'h00);
    wire zero_write = factor_write && (factor_in == 8'h00);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `WDT_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wsel_ok ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // configuration registers
    logic seconds_unit_select;
    logic [`WDT_EVT_W-1:0] mask_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seconds_unit_select <= `WDT_UNIT_RESET;
            mask_reg <= `WDT_MASK_RESET;
        end else begin
            if (lane0 && wsel_unit) begin
                seconds_unit_select <= wdata_reg[`WDT_UNIT_SEC_BIT];
            end
            if (lane0 && wsel_mask) begin
                mask_reg <= wdata_reg[`WDT_EVT_W-1:0];
            end
        end
    end

    // unit tick generation
    tick_if sec_tk();
    tick_if min_tk();
    watchdog_pkg::wd_state_type state_reg;
    watchdog_pkg::wd_state_type state_next;
    wire running = (state_reg == watchdog_pkg::WD_COUNTING);

    assign sec_tk.clear = factor_write || !running;
    assign sec_tk.advance = running;
    assign min_tk.clear = factor_write || !running;
    assign min_tk.advance = sec_tk.tick;

    pulse_divider #(.LIMIT(SECOND_CYCLES)) sec_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tk(sec_tk.source)
    );

    pulse_divider #(.LIMIT(`WDT_MINUTE_TICKS)) min_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .tk(min_tk.source)
    );

    wire unit_tick = seconds_unit_select ? sec_tk.tick : min_tk.tick;

    // countdown and state
    logic [7:0] count_reg;
    logic [7:0] factor_reg;
    logic fire;
    logic rst_active;
    wire last_unit = running && unit_tick && (count_reg == 8'h01) && !factor_write;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            watchdog_pkg::WD_DISABLED: begin
                if (trigger_write) begin
                    state_next = watchdog_pkg::WD_COUNTING;
                end
            end
            watchdog_pkg::WD_COUNTING: begin
                if (zero_write) begin
                    state_next = watchdog_pkg::WD_DISABLED;
                end else if (last_unit) begin
                    state_next = watchdog_pkg::WD_EXPIRED;
                end
            end
            watchdog_pkg::WD_EXPIRED: begin
                if (!rst_active && !fire) begin
                    state_next = watchdog_pkg::WD_DISABLED;
                end
            end
            default: begin
                state_next = watchdog_pkg::WD_DISABLED;
            end
        endcase
    end

    assign fire = last_unit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= watchdog_pkg::WD_DISABLED;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= `WDT_FACTOR_RESET;
            factor_reg <= `WDT_FACTOR_RESET;
        end else if (trigger_write && !(state_reg == watchdog_pkg::WD_EXPIRED)) begin
            count_reg <= factor_in;
            factor_reg <= factor_in;
        end else if (zero_write) begin
            count_reg <= `WDT_FACTOR_RESET;
        end else if (running && unit_tick) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    reset_pulse_gen #(.CYCLES(`WDT_RST_PULSE_CYCLES)) rst_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .fire(fire),
        .active(rst_active)
    );

    assign system_reset = rst_active;

    // indicator toggles each second while counting
    always_ff @(posedge aclk) begin
        if (!aresetn || !running) begin
            activity_led <= 1'b0;
        end else if (sec_tk.tick) begin
            activity_led <= !activity_led;
        end
    end

    // read channel
    wire ar_take = arvalid && arready;
    assign arready = !rvalid;
    wire rsel_factor = (araddr == `WDT_FACTOR_ADDR);
    wire rsel_unit = (araddr == `WDT_UNIT_ADDR);
    wire rsel_state = (araddr == `WDT_STATE_ADDR);
    wire rsel_event = (araddr == `WDT_EVENT_ADDR);
    wire rsel_mask = (araddr == `WDT_MASK_ADDR);
    wire event_read = ar_take && rsel_event;
    logic [`WDT_EVT_W-1:0] event_reg;
    logic [31:0] read_mux;
    logic read_ok;

    always_comb begin
        read_mux = 32'h0000_0000;
        read_ok = 1'b1;
        if (rsel_factor) begin
            read_mux = 32'h0000_0000;
        end else if (rsel_unit) begin
            read_mux[`WDT_UNIT_SEC_BIT] = seconds_unit_select;
        end else if (rsel_state) begin
            read_mux[`WDT_STATE_RUN_BIT] = running;
            read_mux[`WDT_STATE_UNIT_BIT] = seconds_unit_select;
            read_mux[`WDT_STATE_FIRE_BIT] = rst_active;
            read_mux[15:8] = count_reg;
            read_mux[23:16] = factor_reg;
        end else if (rsel_event) begin
            read_mux[`WDT_EVT_W-1:0] = event_reg;
        end else if (rsel_mask) begin
            read_mux[`WDT_EVT_W-1:0] = mask_reg;
        end else begin
            read_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `WDT_RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= read_mux;
            rresp <= read_ok ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // sticky events, set beats read clear
    wire [`WDT_EVT_W-1:0] event_set = {zero_write && running, trigger_write, fire};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_reg <= `WDT_EVENT_RESET;
        end else begin
            event_reg <= (event_read ? `WDT_EVENT_RESET : event_reg) | event_set;
        end
    end

    assign irq = |(event_reg & mask_reg);

    // checks
    property p_reset_disabled;
        @(posedge aclk)
        $past(!aresetn) && aresetn |-> state_reg == watchdog_pkg::WD_DISABLED && !system_reset;
    endproperty
    a_reset_disabled: assert property (p_reset_disabled) else $error("not disabled after reset");

    property p_enable_load;
        @(posedge aclk) disable iff (!aresetn)
        trigger_write && state_reg != watchdog_pkg::WD_EXPIRED
        |=> running && count_reg == $past(factor_in);
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("factor not loaded");

    property p_reload;
        @(posedge aclk) disable iff (!aresetn)
        running && trigger_write |=> factor_reg == $past(factor_in) && !system_reset;
    endproperty
    a_reload: assert property (p_reload) else $error("trigger did not reload");

    property p_zero_disables;
        @(posedge aclk) disable iff (!aresetn)
        zero_write && running |=> state_reg == watchdog_pkg::WD_DISABLED ##1 !rst_active;
    endproperty
    a_zero_disables: assert property (p_zero_disables) else $error("zero write did not stop");

    property p_no_fire_idle;
        @(posedge aclk) disable iff (!aresetn)
        state_reg == watchdog_pkg::WD_DISABLED && !system_reset |=> !system_reset;
    endproperty
    a_no_fire_idle: assert property (p_no_fire_idle) else $error("reset fired while idle");

    property p_expire;
        @(posedge aclk) disable iff (!aresetn)
        last_unit |=> state_reg == watchdog_pkg::WD_EXPIRED && system_reset;
    endproperty
    a_expire: assert property (p_expire) else $error("expiry gave no reset");

    property p_count_step;
        @(posedge aclk) disable iff (!aresetn)
        running && unit_tick && count_reg > 8'h01 && !factor_write
        |=> count_reg == $past(count_reg) - 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong");

    property p_led_steady;
        @(posedge aclk) disable iff (!aresetn)
        !running |=> !activity_led;
    endproperty
    a_led_steady: assert property (p_led_steady) else $error("led lit while disabled");

    property p_minute_unit;
        @(posedge aclk) disable iff (!aresetn)
        !seconds_unit_select && unit_tick |-> sec_tk.tick;
    endproperty
    a_minute_unit: assert property (p_minute_unit) else $error("minute tick off second");

    c_enable: cover property (@(posedge aclk) disable iff (!aresetn) trigger_write && !running);
    c_retrigger: cover property (@(posedge aclk) disable iff (!aresetn) trigger_write && running);
    c_expire: cover property (@(posedge aclk) disable iff (!aresetn) $rose(system_reset));
    c_disable: cover property (@(posedge aclk) disable iff (!aresetn) zero_write && running);
endmodule // system_watchdog

// ===== tb.sv
// self-checking bench for system_watchdog over its AXI4-Lite port
// assumes the register map of watchdog_regs.svh and a shortened second tick
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module tb;
    localparam int SC = 10;
    logic aclk;
    logic aresetn;
    logic [`WDT_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [`WDT_ADDR_W-1:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic system_reset;
    logic activity_led;
    logic irq;
    logic led_q;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int n_led = 0;
    int n_rst = 0;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] strb = 4'hF;

    system_watchdog #(.SECOND_CYCLES(SC)) i_system_watchdog (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .system_reset(system_reset), .activity_led(activity_led), .irq(irq)
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // toggles of the indicator and cycles of reset pulse
    always @(posedge aclk) begin
        cyc++;
        if (activity_led !== led_q) n_led++;
        led_q <= activity_led;
        if (system_reset === 1'b1) n_rst++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_count(input int got, input int lo, input int hi, input string msg);
        compares++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("wrong value at %0t: %s got %0d expected %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        int i;
        logic done;
        i = 0;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            i++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        chk_count(i, 3, 3, "write answer latency");
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int i;
        logic done;
        i = 0;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            i++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        chk_count(i, 2, 2, "read answer latency");
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // counts edges from the response of the last factor write to the reset pulse
    task automatic expect_fire(input int exp);
        int c;
        c = 0;
        n_rst = 0;
        while (system_reset !== 1'b1 && c < exp + 50) begin
            @(posedge aclk);
            c++;
        end
        chk_count(c, exp - 1, exp + 1, "cycles to reset pulse");
        wait_cycles(14);
        chk_count(n_rst, 8, 8, "reset pulse width");
    endtask

    initial begin
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        led_q = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk_word({29'h0, system_reset, activity_led, irq}, 32'h0, "outputs after reset");
        rd(`WDT_STATE_ADDR, d, r);
        chk_word(d, 32'h2, "state after reset");
        rd(`WDT_UNIT_ADDR, d, r);
        chk_word(d, 32'h1, "unit after reset");
        rd(`WDT_MASK_ADDR, d, r);
        chk_word(d, 32'h0, "mask after reset");
        rd(`WDT_EVENT_ADDR, d, r);
        chk_word(d, 32'h0, "events after reset");
        rd(`WDT_FACTOR_ADDR, d, r);
        chk_word(d, 32'h0, "factor reads zero");
        rd(8'h20, d, r);
        chk_word({r, d[29:0]}, {2'h2, 30'h0}, "unmapped read");
        wr(8'h20, 32'h5, r);
        chk_word({30'h0, r}, 32'h2, "unmapped write");
        n_rst = 0;
        wait_cycles(40);
        chk_count(n_rst, 0, 0, "no reset while disabled");
        strb = 4'hE;
        wr(`WDT_FACTOR_ADDR, 32'h3, r);
        strb = 4'hF;
        rd(`WDT_STATE_ADDR, d, r);
        chk_word(d & 32'h1, 32'h0, "factor write without lane 0 ignored");
        wr(`WDT_MASK_ADDR, 32'h1, r);
        wr(`WDT_FACTOR_ADDR, 32'h3, r);
        chk_word({30'h0, r}, 32'h0, "factor write okay");
        rd(`WDT_STATE_ADDR, d, r);
        chk_word(d & 32'h00FF0001, 32'h00030001, "counting after enable");
        wait_cycles(15);
        wr(`WDT_FACTOR_ADDR, 32'h3, r);
        expect_fire(3 * SC + 1);
        chk_word({31'h0, irq}, 32'h1, "irq on unmasked expiry");
        rd(`WDT_EVENT_ADDR, d, r);
        chk_word(d, 32'h3, "trigger and expiry events");
        chk_word({31'h0, irq}, 32'h0, "irq after read clear");
        rd(`WDT_STATE_ADDR, d, r);
        chk_word(d & 32'h7, 32'h2, "disabled after expiry");
        wr(`WDT_MASK_ADDR, 32'h0, r);
        wr(`WDT_FACTOR_ADDR, 32'h5, r);
        wait_cycles(5);
        wr(`WDT_FACTOR_ADDR, 32'h2, r);
        expect_fire(2 * SC + 1);
        chk_word({31'h0, irq}, 32'h0, "masked expiry keeps irq low");
        rd(`WDT_EVENT_ADDR, d, r);
        n_led = 0;
        wait_cycles(30);
        chk_count(n_led, 0, 0, "led steady while disabled");
        wr(`WDT_MASK_ADDR, 32'h4, r);
        wr(`WDT_FACTOR_ADDR, 32'h6, r);
        n_led = 0;
        wait_cycles(35);
        chk_count(n_led, 3, 4, "led blinks while counting");
        n_rst = 0;
        wr(`WDT_FACTOR_ADDR, 32'h0, r);
        rd(`WDT_STATE_ADDR, d, r);
        chk_word(d & 32'h1, 32'h0, "stopped by zero write");
        chk_word({31'h0, irq}, 32'h1, "irq on disable event");
        wait_cycles(80);
        chk_count(n_rst, 0, 0, "no reset after disable");
        chk_word({31'h0, activity_led}, 32'h0, "led off after disable");
        rd(`WDT_EVENT_ADDR, d, r);
        chk_word(d, 32'h6, "trigger and disable events");
        chk_word({31'h0, irq}, 32'h0, "irq cleared");
        wr(`WDT_UNIT_ADDR, 32'h0, r);
        wr(`WDT_FACTOR_ADDR, 32'h1, r);
        expect_fire(60 * SC + 1);
        wr(`WDT_UNIT_ADDR, 32'h1, r);
        wr(`WDT_FACTOR_ADDR, 32'hFF, r);
        expect_fire(255 * SC + 1);
        give_verdict();
    end
endmodule // tb
